// ---- xg_fault_mtu.sv ----
/*
  fault response and frame length limit control of a 10 Gb mac, with a
  classic wishbone register slave and a masked level interrupt.
  assumes: lock and fault levels come from other domains and are
  synchronised here; frame lengths arrive on clk_i with a valid pulse.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - rx clock_manager lock shown read-only at config bit 31, 1 = locked.
// - tx clock_manager lock shown read-only at config bit 30, 1 = locked.
// - config bit 29 is 1 while remote fault sets are received.
// - config bit 28 is 1 while local fault sets are received.
// - inhibit bit 27 clear (reset): local fault received sends remote fault.
// - inhibit clear: remote fault received without local fault sends idles instead of mac data.
// - inhibit set: mac transmit data always passes to the link.
// - receive_limit_enable set: receive_limit_size is the max frame length.
// - receive_limit_size at bits 14:0, reset 0x05EE, used only when enabled.
// - transmit_limit_enable set: transmit_limit_size is the max frame length.
// - transmit_limit_size at bits 14:0, reset 0x05EE, used only when enabled.
// - limit disabled: max length comes from jumbo setting, not the size.
// - tx jumbo off: only up to legal maximum; on: longer frames allowed.
module xg_fault_mtu (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // link status, asynchronous levels
  input  wire logic        rx_lock_i,
  input  wire logic        tx_lock_i,
  input  wire logic        rx_local_fault_i,
  input  wire logic        rx_remote_fault_i,
  // transmit sublayer selection
  output xg_fault_mtu_pkg::tx_mode_e tx_mode_o,
  // frame length checks
  input  wire logic [15:0] rx_len_i,
  input  wire logic        rx_len_valid_i,
  output logic             rx_too_long_o,
  input  wire logic [15:0] tx_len_i,
  input  wire logic        tx_len_valid_i,
  output logic             tx_too_long_o,
  // interrupt
  output logic             irq_o
);

  // ==========================================================
  // functions
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // effective limit; unlimited only when jumbo and no size limit
  function automatic logic [15:0] max_len(input xg_fault_mtu_pkg::limit_s l,
                                          input logic jumbo);
    logic [15:0] r;
    r = xg_fault_mtu_pkg::LEGAL_MAX_LEN;
    if (l.enable) begin
      r = {1'b0, l.size};
    end else if (jumbo) begin
      r = xg_fault_mtu_pkg::NO_LIMIT_LEN;
    end
    return r;
  endfunction

  function automatic logic [31:0] limit_word(
    input xg_fault_mtu_pkg::limit_s l);
    return {15'h0000, l.enable, 1'b0, l.size};
  endfunction

  // ==========================================================
  // synchronisers; first stage read only by second
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic [3:0] sync_prev_q;
  wire  [3:0] async_in = {rx_lock_i, tx_lock_i,
                          rx_remote_fault_i, rx_local_fault_i};

  always_ff @(posedge clk_i) begin
    meta_q <= async_in;
    sync_q <= meta_q;
    sync_prev_q <= sync_q;
  end

  wire rx_lock_s = sync_q[3];
  wire tx_lock_s = sync_q[2];
  wire remote_s  = sync_q[1];
  wire local_s   = sync_q[0];

  // ==========================================================
  // bus decode
  xg_fault_mtu_pkg::wb_req_s req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  logic ack_q;
  wire  req_new  = req.cyc & req.stb & ~ack_q;
  wire  wr_fire  = req.cyc & req.stb & ack_q & req.we;
  wire  rd_fire  = req.cyc & req.stb & ack_q & ~req.we;
  wire  hit_cfg  = req.adr == xg_fault_mtu_pkg::FAULT_CFG_OFS;
  wire  hit_rxl  = req.adr == xg_fault_mtu_pkg::RX_LIMIT_OFS;
  wire  hit_txl  = req.adr == xg_fault_mtu_pkg::TX_LIMIT_OFS;
  wire  hit_fctl = req.adr == xg_fault_mtu_pkg::FRAME_CTL_OFS;
  wire  hit_stat = req.adr == xg_fault_mtu_pkg::IRQ_STAT_OFS;
  wire  hit_mask = req.adr == xg_fault_mtu_pkg::IRQ_MASK_OFS;

  // ==========================================================
  // registers
  logic                     inhibit_q;
  xg_fault_mtu_pkg::limit_s rx_lim_q;
  xg_fault_mtu_pkg::limit_s tx_lim_q;
  logic                     rx_jumbo_q;
  logic                     tx_jumbo_q;
  logic [5:0]               stat_q;
  logic [5:0]               mask_q;
  logic [31:0]              rdata_q;

  wire [31:0] cfg_word = {rx_lock_s,
                          tx_lock_s,
                          remote_s,
                          local_s,
                          inhibit_q, 27'h0000000};
  wire [31:0] fctl_word = {30'h00000000, tx_jumbo_q, rx_jumbo_q};

  // reserved and unmapped read as zero
  wire [31:0] rd_word =
    hit_cfg  ? cfg_word :
    hit_rxl  ? limit_word(rx_lim_q) :
    hit_txl  ? limit_word(tx_lim_q) :
    hit_fctl ? fctl_word :
    hit_stat ? {26'h0000000, stat_q} :
    hit_mask ? {26'h0000000, mask_q} : 32'h00000000;

  // only writable fields are taken; status bits dropped
  wire [31:0] cfg_m  = merge(cfg_word, req.dat, req.sel);
  wire [31:0] rxl_m  = merge(limit_word(rx_lim_q), req.dat, req.sel);
  wire [31:0] txl_m  = merge(limit_word(tx_lim_q), req.dat, req.sel);
  wire [31:0] fctl_m = merge(fctl_word, req.dat, req.sel);
  wire [31:0] mask_m = merge({26'h0000000, mask_q}, req.dat, req.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        rdata_q <= rd_word;
      end
    end
  end

  // size is stored unchecked; values under 1518 are software's fault
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit_q  <= xg_fault_mtu_pkg::INHIBIT_RST;
      rx_lim_q   <= '{enable: xg_fault_mtu_pkg::LIMIT_EN_RST,
                      size: xg_fault_mtu_pkg::LIMIT_SIZE_RST};
      tx_lim_q   <= '{enable: xg_fault_mtu_pkg::LIMIT_EN_RST,
                      size: xg_fault_mtu_pkg::LIMIT_SIZE_RST};
      rx_jumbo_q <= 1'b0;
      tx_jumbo_q <= 1'b0;
      mask_q     <= 6'h00;
    end else if (wr_fire) begin
      if (hit_cfg) begin
        inhibit_q <= cfg_m[xg_fault_mtu_pkg::INHIBIT_BIT];
      end
      if (hit_rxl) begin
        rx_lim_q <= {rxl_m[xg_fault_mtu_pkg::LIMIT_EN_BIT], rxl_m[14:0]};
      end
      if (hit_txl) begin
        tx_lim_q <= {txl_m[xg_fault_mtu_pkg::LIMIT_EN_BIT], txl_m[14:0]};
      end
      if (hit_fctl) begin
        rx_jumbo_q <= fctl_m[xg_fault_mtu_pkg::RX_JUMBO_BIT];
        tx_jumbo_q <= fctl_m[xg_fault_mtu_pkg::TX_JUMBO_BIT];
      end
      if (hit_mask) begin
        mask_q <= mask_m[5:0];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================
  // fault response
  xg_fault_mtu_pkg::tx_mode_e mode_d;
  xg_fault_mtu_pkg::tx_mode_e mode_q;

  // local fault outranks remote: our own receive path is broken
  always_comb begin
    case ({inhibit_q, local_s, remote_s})
      3'b010, 3'b011: mode_d = xg_fault_mtu_pkg::TX_REMOTE_FAULT;
      3'b001:         mode_d = xg_fault_mtu_pkg::TX_IDLE;
      default:        mode_d = xg_fault_mtu_pkg::TX_PASS;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= xg_fault_mtu_pkg::TX_PASS;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign tx_mode_o = mode_q;

  // ==========================================================
  // frame length limits
  wire [15:0] rx_max = max_len(rx_lim_q, rx_jumbo_q);
  wire [15:0] tx_max = max_len(tx_lim_q, tx_jumbo_q);
  wire rx_long_d = rx_len_valid_i & (rx_len_i > rx_max);
  wire tx_long_d = tx_len_valid_i & (tx_len_i > tx_max);
  logic rx_long_q;
  logic tx_long_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_long_q <= 1'b0;
      tx_long_q <= 1'b0;
    end else begin
      rx_long_q <= rx_long_d;
      tx_long_q <= tx_long_d;
    end
  end

  assign rx_too_long_o = rx_long_q;
  assign tx_too_long_o = tx_long_q;

  // ==========================================================
  // interrupts
  wire [5:0] ev = {tx_long_d, rx_long_d,
                   sync_prev_q[2] & ~tx_lock_s,
                   sync_prev_q[3] & ~rx_lock_s,
                   remote_s & ~sync_prev_q[1],
                   local_s & ~sync_prev_q[0]};
  // clear only what the read returned, so a later event survives
  wire [5:0] clr = (rd_fire & hit_stat) ? rdata_q[5:0] : 6'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= 6'h00;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rx_lock_bit: assert property (
    cfg_word[31] == $past(rx_lock_i, 2))
    else $error("rx lock bit wrong");
  a_tx_lock_bit: assert property (
    cfg_word[30] == $past(tx_lock_i, 2))
    else $error("tx lock bit wrong");
  a_remote_bit: assert property (
    cfg_word[29] == $past(rx_remote_fault_i, 2))
    else $error("remote fault bit wrong");
  a_local_bit: assert property (
    cfg_word[28] == $past(rx_local_fault_i, 2))
    else $error("local fault bit wrong");
  a_remote_reply: assert property (!inhibit_q && local_s |=>
    tx_mode_o == xg_fault_mtu_pkg::TX_REMOTE_FAULT)
    else $error("no remote fault reply");
  a_idle_reply: assert property (
    !inhibit_q && !local_s && remote_s |=>
    tx_mode_o == xg_fault_mtu_pkg::TX_IDLE)
    else $error("no idle reply");
  a_inhibit_pass: assert property (inhibit_q |=>
    tx_mode_o == xg_fault_mtu_pkg::TX_PASS)
    else $error("inhibit did not pass data");
  a_rx_limit_use: assert property (
    rx_len_valid_i && rx_lim_q.enable |=>
    rx_too_long_o == ($past(rx_len_i) > {1'b0, $past(rx_lim_q.size)}))
    else $error("rx limit misapplied");
  a_tx_limit_use: assert property (
    tx_len_valid_i && tx_lim_q.enable |=>
    tx_too_long_o == ($past(tx_len_i) > {1'b0, $past(tx_lim_q.size)}))
    else $error("tx limit misapplied");
  a_tx_jumbo_off: assert property (
    tx_len_valid_i && !tx_lim_q.enable && !tx_jumbo_q |=>
    tx_too_long_o == ($past(tx_len_i) > 16'h05EE))
    else $error("legal max not applied");
  a_rx_size_ignore: assert property (
    rx_len_valid_i && !rx_lim_q.enable && rx_jumbo_q |=> !rx_too_long_o)
    else $error("size used while disabled");
  // pins may move during the write, so compare against the pins two back
  a_status_ro: assert property (wr_fire && hit_cfg |=>
    cfg_word[31:28] == $past(async_in, 2) && cfg_word[26:0] == 27'h0000000)
    else $error("status bits written");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

endmodule

`default_nettype wire

// ---- xg_fault_mtu_pkg.sv ----
/*
  constants, field layouts and carrier types for the fault signalling and
  frame length limit block of a 10 Gb mac.
  assumes: one 10 MHz clock domain, classic wishbone register access.
*/
`default_nettype none

package xg_fault_mtu_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] FAULT_CFG_OFS  = 8'h00;
  localparam logic [7:0] RX_LIMIT_OFS   = 8'h04;
  localparam logic [7:0] TX_LIMIT_OFS   = 8'h08;
  localparam logic [7:0] FRAME_CTL_OFS  = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h14;

  // ==========================================================
  // field positions
  localparam int RX_LOCK_BIT    = 31;
  localparam int TX_LOCK_BIT    = 30;
  localparam int REMOTE_BIT     = 29;
  localparam int LOCAL_BIT      = 28;
  localparam int INHIBIT_BIT    = 27;
  localparam int LIMIT_EN_BIT   = 16;
  localparam int RX_JUMBO_BIT   = 0;
  localparam int TX_JUMBO_BIT   = 1;

  // ==========================================================
  // reset values and fixed lengths
  localparam logic       INHIBIT_RST    = 1'b0;
  localparam logic       LIMIT_EN_RST   = 1'b0;
  localparam logic [14:0] LIMIT_SIZE_RST = 15'h05EE;
  localparam logic [15:0] LEGAL_MAX_LEN  = 16'h05EE;
  localparam logic [15:0] NO_LIMIT_LEN   = 16'hFFFF;

  // ==========================================================
  // interrupt event positions
  localparam int EV_LOCAL_ON    = 0;
  localparam int EV_REMOTE_ON   = 1;
  localparam int EV_RX_UNLOCK   = 2;
  localparam int EV_TX_UNLOCK   = 3;
  localparam int EV_RX_LONG     = 4;
  localparam int EV_TX_LONG     = 5;
  localparam int EV_W           = 6;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic        enable;
    logic [14:0] size;
  } limit_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic [2:0] {
    TX_PASS         = 3'b001,
    TX_REMOTE_FAULT = 3'b010,
    TX_IDLE         = 3'b100
  } tx_mode_e;

endpackage

`default_nettype wire

// ---- xg_phy_model.sv ----
/*
  phy side model: clock manager lock levels and received fault levels.
  assumes: the bench selects the fault kind (bit 0 local, bit 1 remote,
  both at once allowed) and can force loss of lock.
*/
`timescale 1ns/1ps
`default_nettype none

module xg_phy_model (
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       unlock_i,
  input  wire logic [1:0] fault_i,
  // link status levels
  output logic            rx_lock_o,
  output logic            tx_lock_o,
  output logic            local_fault_o,
  output logic            remote_fault_o
);
  // ==========================================================
  // lock timing
  // tx locks later than rx, so the two lock bits are told apart
  logic [3:0] lock_cnt_q = 4'h0;

  always @(posedge clk_i) begin
    if (unlock_i) begin
      lock_cnt_q <= 4'h0;
    end else if (lock_cnt_q != 4'hF) begin
      lock_cnt_q <= lock_cnt_q + 4'h1;
    end
  end

  assign rx_lock_o      = (lock_cnt_q >= 4'h8);
  assign tx_lock_o      = (lock_cnt_q >= 4'hC);
  assign local_fault_o  = fault_i[0];
  assign remote_fault_o = fault_i[1];
endmodule

`default_nettype wire

// ---- xg_fault_mtu_tb_top.sv ----
/*
  self-checking bench: register, fault response, length and irq scenarios.
  assumes: package and phy model compiled first; 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module xg_fault_mtu_tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        cyc      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [3:0]  be       = 4'hF;
  logic        unlock   = 1'b0;
  logic [1:0]  fault    = 2'h0;
  logic [15:0] rx_len   = 16'h0;
  logic [15:0] tx_len   = 16'h0;
  logic        rx_len_v = 1'b0;
  logic        tx_len_v = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        rx_lock;
  logic        tx_lock;
  logic        loc_f;
  logic        rem_f;
  logic        rx_long;
  logic        tx_long;
  logic        irq;
  logic [31:0] r;
  xg_fault_mtu_pkg::tx_mode_e mode;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  xg_fault_mtu i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rx_lock_i(rx_lock),
    .tx_lock_i(tx_lock), .rx_local_fault_i(loc_f),
    .rx_remote_fault_i(rem_f), .tx_mode_o(mode), .rx_len_i(rx_len),
    .rx_len_valid_i(rx_len_v), .rx_too_long_o(rx_long), .tx_len_i(tx_len),
    .tx_len_valid_i(tx_len_v), .tx_too_long_o(tx_long), .irq_o(irq));

  xg_phy_model i_phy (
    .clk_i(clk_i), .unlock_i(unlock), .fault_i(fault), .rx_lock_o(rx_lock),
    .tx_lock_o(tx_lock), .local_fault_o(loc_f), .remote_fault_o(rem_f));

  // ==========================================================
  // verdict, timeout and compares
  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: word %h, want %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: flag %b, want %b", $time, g, e);
    end
  endtask

  task automatic chk_mode(input xg_fault_mtu_pkg::tx_mode_e e);
    samples_checked++;
    if (mode !== e) begin
      n_fail++;
      $display("unexpected at %0t: tx mode %b, want %b", $time, mode, e);
    end
  endtask

  // ==========================================================
  // bus and stimulus helpers
  // master never assumes a latency; only the bench timeout ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    // ack is registered: seen on the second edge of the request
    chk_bit(n == 2, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk_word(r, e);
  endtask

  task automatic set_fault(input logic [1:0] f);
    @(posedge clk_i);
    fault <= f;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic len_case(input logic tx, input logic [15:0] l, input logic e);
    @(posedge clk_i);
    if (tx) begin
      tx_len <= l;
      tx_len_v <= 1'b1;
    end else begin
      rx_len <= l;
      rx_len_v <= 1'b1;
    end
    @(posedge clk_i);
    tx_len_v <= 1'b0;
    rx_len_v <= 1'b0;
    @(posedge clk_i);
    chk_bit(tx ? tx_long : rx_long, e);
    @(posedge clk_i);
    chk_bit(tx ? tx_long : rx_long, 1'b0);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk(8'h00, 32'hC000_0000);
    rd_chk(8'h04, 32'h0000_05EE);
    rd_chk(8'h08, 32'h0000_05EE);
    chk_mode(xg_fault_mtu_pkg::TX_PASS);
  endtask

  task automatic t_faults();
    set_fault(2'h1);
    chk_mode(xg_fault_mtu_pkg::TX_REMOTE_FAULT);
    rd_chk(8'h00, 32'hD000_0000);
    set_fault(2'h2);
    chk_mode(xg_fault_mtu_pkg::TX_IDLE);
    rd_chk(8'h00, 32'hE000_0000);
    // both faults at once: the local one wins
    set_fault(2'h3);
    chk_mode(xg_fault_mtu_pkg::TX_REMOTE_FAULT);
    rd_chk(8'h00, 32'hF000_0000);
    wb(1'b1, 8'h00, 32'h0800_0000);
    repeat (2) @(posedge clk_i);
    chk_mode(xg_fault_mtu_pkg::TX_PASS);
    set_fault(2'h1);
    chk_mode(xg_fault_mtu_pkg::TX_PASS);
    set_fault(2'h0);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rd_chk(8'h00, 32'hC800_0000);
    wb(1'b1, 8'h00, 32'h0);
  endtask

  task automatic t_lengths();
    len_case(1'b0, 16'h05EE, 1'b0);
    len_case(1'b0, 16'h05EF, 1'b1);
    len_case(1'b1, 16'h05EE, 1'b0);
    len_case(1'b1, 16'h05EF, 1'b1);
    wb(1'b1, 8'h04, 32'h0000_07D0);
    len_case(1'b0, 16'h05EF, 1'b1);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    len_case(1'b0, 16'hFFFF, 1'b0);
    len_case(1'b1, 16'h0640, 1'b0);
    wb(1'b1, 8'h04, 32'h0001_07D0);
    wb(1'b1, 8'h08, 32'h0001_07D0);
    rd_chk(8'h04, 32'h0001_07D0);
    len_case(1'b0, 16'h07D0, 1'b0);
    len_case(1'b0, 16'h07D1, 1'b1);
    len_case(1'b1, 16'h07D0, 1'b0);
    len_case(1'b1, 16'h07D1, 1'b1);
    wb(1'b1, 8'h08, 32'hFFFF_FFFF);
    rd_chk(8'h08, 32'h0001_7FFF);
    // byte enables: only the low byte of the size changes
    be <= 4'h1;
    wb(1'b1, 8'h08, 32'h0000_0000);
    be <= 4'hF;
    rd_chk(8'h08, 32'h0001_7F00);
  endtask

  // events of earlier scenarios are checked and cleared by the first read
  task automatic t_irq();
    rd_chk(8'h10, 32'h0000_0033);
    wb(1'b1, 8'h14, 32'h0000_0004);
    @(posedge clk_i);
    unlock <= 1'b1;
    repeat (2) @(posedge clk_i);
    unlock <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_bit(irq, 1'b1);
    rd_chk(8'h10, 32'h0000_000C);
    @(posedge clk_i);
    chk_bit(irq, 1'b0);
    wb(1'b1, 8'h14, 32'h0);
    repeat (14) @(posedge clk_i);
    unlock <= 1'b1;
    repeat (2) @(posedge clk_i);
    unlock <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_bit(irq, 1'b0);
    rd_chk(8'h10, 32'h0000_000C);
    rd_chk(8'h1C, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_faults();
    t_lengths();
    t_irq();
    final_report();
  end
endmodule

`default_nettype wire
